// [logic/led_fault_map.svh]
// constants for the led driver fault supervisor: counts and field positions
// assumes inclusion by bare name from the design files
`ifndef LED_FAULT_MAP_SVH
`define LED_FAULT_MAP_SVH
// internal clock cycles of low level needed to clear a latched fault
`define CLEAR_COUNT_STD 32'h00008000
`define CLEAR_COUNT_LOW_FREQ 32'h00002000
// width of the clearing counter
`define CLEAR_CNT_W 16
// switching clock half-period terminal count, output toggles every 26 cycles (plain default)
`define SWCLK_HALF_DIV 8'h19
// overvoltage resume threshold in percent of the trip level
`define OV_RESUME_PCT 7'h5E
// fault input vector positions
`define FLT_IDC_OC 0
`define FLT_SW_OC2 1
`define FLT_SW_OV2 2
`define FLT_LATCH_W 3
`endif

// [logic/led_fault_pkg.sv]
// types for the led driver fault supervisor
// no assumptions beyond a SystemVerilog compiler
package led_fault_pkg;
    typedef enum logic [1:0] {
        ST_OFF = 2'h0,
        ST_RUN = 2'h1,
        ST_LATCHED = 2'h3
    } sup_state_t;
endpackage

// [logic/latch_clear_counter.sv]
// counter of continuous low cycles on enable or dimming for latch clearing
// assumes inputs synchronous to sys_clk
`timescale 1ns/1ns
`include "led_fault_map.svh"
module latch_clear_counter #(
    parameter int CNT_W = `CLEAR_CNT_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control
    input wire logic count_en,
    input wire logic [CNT_W-1:0] target,
    // result
    output logic done
);
    if (CNT_W < 14) begin : g_cnt_w_check
        $error("clear counter too narrow");
    end
    logic [CNT_W-1:0] cnt;
    wire logic at_target = (cnt >= target);
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= '0;
            done <= 1'b0;
        end else if (!count_en) begin
            cnt <= '0;
            done <= 1'b0;
        end else begin
            if (!at_target) cnt <= cnt + 1'b1;
            done <= at_target; // more than target cycles low
        end
    end
endmodule // latch_clear_counter

// [logic/led_fault_supervisor.sv]
// fault supervision and recovery for a boost led backlight driver
// assumes comparator outputs already debounced and synchronous to sys_clk
//
// Operation
// - open string: raise output to overvoltage, drop unregulated strings, no fault flag.
// - current-set overcurrent stops boost and sinks, disconnect stays on, no flag.
// - frequency-set overcurrent shuts everything, flags fault, restarts with soft-start.
// - overvoltage halts boost only, resumes at about 94 percent, no flag.
// - output rail undervoltage stops boost and sinks, flags fault, auto-restarts.
// - partial short disables string if another pin below 1.2 V, no flag.
// - partial short string re-enabled when pin drops or next dimming rise.
// - overtemperature shuts everything, flags fault, restarts after hysteresis.
// - supply lockout shuts everything, clears latches, fault flag released.
// - only disconnect overcurrent, switch overcurrent2, switch overvoltage2 latch.
// - enable low for over 32k cycles clears latched fault.
// - dimming low over 32k cycles (8k low-frequency variant) clears latch.
// - clearing by dimming keeps switching clock running.
// - latching condition still present after clear trips again.
// - latched mode drives fault low while switching clock continues.
// - clearing count done leaves latched mode and releases fault.
// - latched device refuses start even with dimming high.
// - after clear, restart at next dimming high level.
// - faults monitored in every state and transition.
// - switch overcurrent2 shuts all outputs and latches with fault flag.
`timescale 1ns/1ns
`include "led_fault_map.svh"
module led_fault_supervisor #(
    parameter int STRINGS = 4,
    parameter bit LOW_FREQ_VARIANT = 1'b0,
    parameter int CNT_W = `CLEAR_CNT_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // host inputs
    input wire logic enable,
    input wire logic dimming,
    // analog comparator flags
    input wire logic supply_undervoltage_lockout,
    input wire logic temp_over,
    input wire logic temp_below_hysteresis,
    input wire logic current_set_pin_over,
    input wire logic frequency_set_pin_over,
    input wire logic overvoltage_sense,
    input wire logic overvoltage_below_resume,
    input wire logic boost_output_rail_under,
    input wire logic disconnect_overcurrent,
    input wire logic switch_overcurrent_secondary,
    input wire logic switch_overvoltage_secondary,
    // per string comparators
    input wire logic [STRINGS-1:0] string_out_of_reg,
    input wire logic [STRINGS-1:0] string_above_partial_short,
    input wire logic [STRINGS-1:0] string_below_low_level,
    // power stage controls
    output logic boost_enable,
    output logic disconnect_on,
    output logic [STRINGS-1:0] sink_enable,
    output logic soft_start_req,
    output logic switching_clock_output,
    // open-drain fault pin, enable high pulls low
    output logic fault_out,
    output logic fault_oe,
    output logic latched_mode
);
    // elaboration checks on the parameters
    if (STRINGS < 2 || STRINGS > 16) begin : g_strings_check
        $error("STRINGS out of range");
    end
    if (CNT_W < 16) begin : g_cnt_w_check
        $error("CNT_W too narrow for the enable clearing count");
    end

    // enable low always needs the long count, dimming low the variant count
    localparam logic [CNT_W-1:0] EN_TARGET = CNT_W'(`CLEAR_COUNT_STD);
    localparam logic [CNT_W-1:0] DIM_TARGET = LOW_FREQ_VARIANT ?
        CNT_W'(`CLEAR_COUNT_LOW_FREQ) : CNT_W'(`CLEAR_COUNT_STD);

    led_fault_pkg::sup_state_t state;
    led_fault_pkg::sup_state_t next_state;

    logic ov_hold;
    logic temp_hold;
    logic frequency_set_pin_hold;
    logic dimming_d;
    logic [STRINGS-1:0] open_drop;
    logic [STRINGS-1:0] short_drop;
    logic ov_seen;
    logic [7:0] div_cnt;

    // latching causes
    wire logic latch_cause = disconnect_overcurrent | switch_overcurrent_secondary |
        switch_overvoltage_secondary;
    wire logic dim_rise = dimming & ~dimming_d;
    wire logic clear_count_en = latched_mode & (~enable | (enable & ~dimming));
    wire logic clear_done;
    wire logic [CNT_W-1:0] clear_target = enable ? DIM_TARGET : EN_TARGET;

    latch_clear_counter #(
        .CNT_W(CNT_W)
    ) i_latch_clear_counter (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .count_en(clear_count_en),
        .target(clear_target),
        .done(clear_done)
    );

    // hysteretic auto-restart faults
    wire logic next_ov_hold = overvoltage_sense | (ov_hold & ~overvoltage_below_resume);
    wire logic next_temp_hold = temp_over | (temp_hold & ~temp_below_hysteresis);
    wire logic any_pin_low = |string_below_low_level;

    function automatic logic other_low(input logic [STRINGS-1:0] low, input int idx);
        logic [STRINGS-1:0] m;
        m = low;
        m[idx] = 1'b0;
        return |m;
    endfunction

    // state transitions, checked every cycle in every state
    always_comb begin
        next_state = state;
        case (state)
            led_fault_pkg::ST_OFF: begin
                if (latch_cause) next_state = led_fault_pkg::ST_LATCHED;
                else if (enable && dimming) next_state = led_fault_pkg::ST_RUN;
            end
            led_fault_pkg::ST_RUN: begin
                if (latch_cause) next_state = led_fault_pkg::ST_LATCHED;
                else if (!enable) next_state = led_fault_pkg::ST_OFF;
            end
            led_fault_pkg::ST_LATCHED: begin
                if (clear_done) next_state = led_fault_pkg::ST_OFF;
            end
            default: next_state = led_fault_pkg::ST_OFF;
        endcase
    end

    wire logic running = (state == led_fault_pkg::ST_RUN);
    // shared shutdown terms
    wire logic full_off = supply_undervoltage_lockout | temp_hold | frequency_set_pin_hold | ~running |
        latch_cause;
    wire logic boost_off = full_off | current_set_pin_over | boost_output_rail_under | ov_hold;
    wire logic sinks_off = full_off | current_set_pin_over | boost_output_rail_under;
    wire logic next_fault = ~supply_undervoltage_lockout & (frequency_set_pin_hold | boost_output_rail_under |
        temp_hold | (next_state == led_fault_pkg::ST_LATCHED));

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= led_fault_pkg::ST_OFF;
        end else if (supply_undervoltage_lockout) begin
            state <= led_fault_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // fault holds and input history
    wire logic next_ov_seen = running & (|string_out_of_reg) & (ov_seen | overvoltage_sense);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ov_hold <= 1'b0;
        end else begin
            ov_hold <= next_ov_hold;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            temp_hold <= 1'b0;
        end else begin
            temp_hold <= next_temp_hold;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frequency_set_pin_hold <= 1'b0;
        end else begin
            frequency_set_pin_hold <= frequency_set_pin_over;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dimming_d <= 1'b0;
        end else begin
            dimming_d <= dimming;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ov_seen <= 1'b0;
        end else begin
            ov_seen <= next_ov_seen;
        end
    end

    // open strings dropped once output reached overvoltage, cleared at new start
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            open_drop <= '0;
        end else if (!running) begin
            open_drop <= '0;
        end else if (overvoltage_sense || ov_seen) begin
            open_drop <= open_drop | string_out_of_reg;
        end
    end

    // partial short string removal and re-enable
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            short_drop <= '0;
        end else begin
            for (int i = 0; i < STRINGS; i++) begin
                if (string_above_partial_short[i] && !string_out_of_reg[i] &&
                    other_low(string_below_low_level, i) && any_pin_low) begin
                    short_drop[i] <= 1'b1;
                end else if (!string_above_partial_short[i] || dim_rise) begin
                    short_drop[i] <= 1'b0;
                end
            end
        end
    end

    // switching clock keeps running in every state
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt <= 8'h00;
            switching_clock_output <= 1'b0;
        end else if (div_cnt == `SWCLK_HALF_DIV) begin
            div_cnt <= 8'h00;
            switching_clock_output <= ~switching_clock_output;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // next values of the registered outputs
    wire logic next_boost_enable = ~boost_off & dimming;
    wire logic next_disconnect_on = ~full_off;
    wire logic [STRINGS-1:0] next_sink_enable = (sinks_off | ~dimming) ? '0 :
        ~(open_drop | short_drop);
    wire logic next_soft_start_req = running & ~full_off & ~disconnect_on;
    wire logic next_latched_mode = (next_state == led_fault_pkg::ST_LATCHED) &
        ~supply_undervoltage_lockout;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boost_enable <= 1'b0;
        end else begin
            boost_enable <= next_boost_enable;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            disconnect_on <= 1'b0;
        end else begin
            disconnect_on <= next_disconnect_on;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sink_enable <= '0;
        end else begin
            sink_enable <= next_sink_enable;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            soft_start_req <= 1'b0;
        end else begin
            soft_start_req <= next_soft_start_req;
        end
    end

    // open-drain data stays low, the enable does the signalling
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_out <= 1'b0;
        end else begin
            fault_out <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_oe <= 1'b0;
        end else begin
            fault_oe <= next_fault;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            latched_mode <= 1'b0;
        end else begin
            latched_mode <= next_latched_mode;
        end
    end
endmodule // led_fault_supervisor

// [verification/led_fault_supervisor_properties.sv]
// assertions on the led fault supervisor ports
// assumes bind to led_fault_supervisor, one clock domain
`timescale 1ns/1ns
module fault_checker #(
    parameter int STRINGS = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // inputs
    input wire logic enable,
    input wire logic dimming,
    input wire logic supply_undervoltage_lockout,
    input wire logic temp_over,
    input wire logic frequency_set_pin_over,
    input wire logic boost_output_rail_under,
    input wire logic disconnect_overcurrent,
    input wire logic switch_overcurrent_secondary,
    input wire logic switch_overvoltage_secondary,
    // outputs
    input wire logic boost_enable,
    input wire logic disconnect_on,
    input wire logic [STRINGS-1:0] sink_enable,
    input wire logic switching_clock_output,
    input wire logic fault_out,
    input wire logic fault_oe,
    input wire logic latched_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire logic lock = supply_undervoltage_lockout;
    wire logic sco = switching_clock_output;
    wire logic cause = disconnect_overcurrent | switch_overcurrent_secondary | switch_overvoltage_secondary;
    wire logic off = !boost_enable && !disconnect_on && sink_enable == '0;
    AST_LATCH: assert property (cause && !lock ##1 !lock ##1 !lock |-> ##[0:1] latched_mode && fault_oe)
        else $error("latch cause not latched");
    AST_LATCH_OFF: assert property (latched_mode |-> off && fault_oe && !fault_out)
        else $error("latched outputs wrong");
    AST_REFUSE: assert property ((latched_mode && enable && dimming && !lock)[*2] |=> latched_mode)
        else $error("latched start not refused");
    AST_LOCKOUT: assert property (lock[*4] |-> off && !fault_oe && !latched_mode)
        else $error("lockout outputs wrong");
    AST_FREQUENCY_SET_PIN: assert property ((frequency_set_pin_over && !lock)[*4] |-> off && fault_oe)
        else $error("frequency set fault outputs wrong");
    AST_UNDER: assert property ((boost_output_rail_under && !lock)[*4] |-> !boost_enable && fault_oe)
        else $error("output undervoltage outputs wrong");
    AST_TEMP: assert property ((temp_over && !lock)[*4] |-> off && fault_oe)
        else $error("overtemperature outputs wrong");
    AST_SWCLK: assert property ($changed(sco) |-> ##26 $changed(sco))
        else $error("switching clock stopped");
    AST_SWCLK_HOLD: assert property ($changed(sco) |=> $stable(sco)[*8])
        else $error("switching clock toggles too fast");
    AST_LATCH_ONLY: assert property ($rose(latched_mode) |-> $past(cause))
        else $error("latched without a latching cause");
endmodule // fault_checker

bind led_fault_supervisor fault_checker #(.STRINGS(STRINGS)) i_fault_checker (
    .sys_clk, .sys_rst, .enable, .dimming, .supply_undervoltage_lockout, .temp_over,
    .frequency_set_pin_over, .boost_output_rail_under, .disconnect_overcurrent,
    .switch_overcurrent_secondary, .switch_overvoltage_secondary, .boost_enable, .disconnect_on,
    .sink_enable, .switching_clock_output, .fault_out, .fault_oe, .latched_mode
);

// [verification/host_ctrl.sv]
// host model driving the enable and dimming levels
// assumes calls start just after a rising edge of sys_clk
`timescale 1ns/1ns
module host_ctrl (
    // clock
    input wire logic sys_clk,
    // host levels
    output logic enable,
    output logic dimming
);
    initial begin
        enable = 1'b0;
        dimming = 1'b0;
    end
    // set both levels and hold them for a number of cycles
    task automatic hold(input logic en, input logic dim, input int cycles);
        enable = en;
        dimming = dim;
        repeat (cycles) @(posedge sys_clk);
        #1;
    endtask
endmodule // host_ctrl

// [verification/testbench.sv]
// self-checking bench for the led fault supervisor
// assumes the host model drives enable and dimming
`timescale 1ns/1ns
module testbench;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [10:0] flags = 11'h044;
    logic [3:0] oor = 4'h0;
    logic [3:0] aps = 4'h0;
    logic [3:0] bll = 4'h0;
    wire logic enable, dimming, boost_enable, disconnect_on, switching_clock_output, fault_oe, latched_mode;
    wire logic [3:0] sink_enable;
    wire logic soft_start_req;
    int n_ss = 0;
    wire logic [6:0] outs = {boost_enable, disconnect_on, sink_enable, fault_oe};
    int n_errors = 0;
    int n_checks = 0;
    int n_tog = 0;
    int n_fall = 0;
    int t0, f0;
    int fbit[5] = '{3, 4, 5, 7, 1};
    logic [6:0] fexp[5] = '{7'h20, 7'h01, 7'h3E, 7'h21, 7'h01};
    always #5 sys_clk = ~sys_clk;
    always @(switching_clock_output) n_tog++;
    always @(negedge latched_mode) n_fall++;
    always @(posedge sys_clk) if (soft_start_req) n_ss++;
    host_ctrl i_host_ctrl (.sys_clk, .enable, .dimming);
    led_fault_supervisor #(.STRINGS(4), .LOW_FREQ_VARIANT(1'b1)) i_led_fault_supervisor (
        .sys_clk, .sys_rst, .enable, .dimming, .supply_undervoltage_lockout(flags[0]), .temp_over(flags[1]),
        .temp_below_hysteresis(flags[2]), .current_set_pin_over(flags[3]), .frequency_set_pin_over(flags[4]),
        .overvoltage_sense(flags[5]), .overvoltage_below_resume(flags[6]), .boost_output_rail_under(flags[7]),
        .disconnect_overcurrent(flags[8]), .switch_overcurrent_secondary(flags[9]),
        .switch_overvoltage_secondary(flags[10]), .string_out_of_reg(oor), .string_above_partial_short(aps),
        .string_below_low_level(bll), .boost_enable, .disconnect_on, .sink_enable, .soft_start_req,
        .switching_clock_output, .fault_out(), .fault_oe, .latched_mode
    );
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic run_ok();
        for (int k = 0; k < 300 && outs !== 7'h7E; k++) tick(1);
        check("running", outs, 7'h7E);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        tick(6);
        sys_rst = 1'b0;
        tick(1);
        i_host_ctrl.hold(1'b1, 1'b1, 1);
        run_ok();
        for (int i = 0; i < 5; i++) begin
            flags[fbit[i]] = 1'b1;
            flags[2] = 1'b0;
            flags[6] = 1'b0;
            tick(4);
            check("fault outputs", outs, fexp[i]);
            flags = 11'h044;
            run_ok();
        end
        aps = 4'h2;
        bll = 4'h4;
        tick(4);
        check("partial short", outs, 7'h7A);
        aps = 4'h0;
        tick(4);
        check("short gone", outs, 7'h7E);
        check("soft start pulses", n_ss, 3);
        oor = 4'h8;
        flags = 11'h024;
        tick(4);
        flags = 11'h044;
        tick(4);
        check("open string", outs, 7'h6E);
        oor = 4'h0;
        for (int i = 8; i < 11; i++) begin
            flags[i] = 1'b1;
            tick(3);
            check("latched", {latched_mode, outs}, 8'h81);
            if (i == 10) begin
                f0 = n_fall;
                t0 = n_tog;
                i_host_ctrl.hold(1'b1, 1'b0, 8300);
                check("relatch", n_fall - f0, 1);
                check("still latched", latched_mode, 1);
                check("clock kept", n_tog - t0 > 300, 1);
            end
            flags[i] = 1'b0;
            i_host_ctrl.hold(1'b1, 1'b1, 20);
            check("refused", {latched_mode, boost_enable}, 2'h2);
            if (i == 9) begin
                i_host_ctrl.hold(1'b1, 1'b0, 8000);
                i_host_ctrl.hold(1'b1, 1'b1, 1);
                i_host_ctrl.hold(1'b1, 1'b0, 8000);
                check("count restarted", latched_mode, 1);
            end
            if (i == 8) begin
                i_host_ctrl.hold(1'b0, 1'b1, 8300);
                check("enable count long", latched_mode, 1);
                i_host_ctrl.hold(1'b0, 1'b1, 24500);
            end else i_host_ctrl.hold(1'b1, 1'b0, 8300);
            check("cleared", {latched_mode, fault_oe}, 2'h0);
            i_host_ctrl.hold(1'b1, 1'b1, 1);
            run_ok();
        end
        flags[9] = 1'b1;
        tick(3);
        flags = 11'h045;
        tick(4);
        check("lockout", {latched_mode, outs}, 8'h00);
        flags = 11'h044;
        run_ok();
        results();
    end
    initial begin
        #1000000;
        n_errors++;
        results();
    end
endmodule // testbench
